// ===== wdrs_map.vh
// Register offsets, field positions, reset values and timing counts of the watchdog and reset-source block.
`ifndef WDRS_MAP_VH
`define WDRS_MAP_VH
// ==========================================================================
// Register byte addresses (printed offsets are not all multiples of four).
`define WDRS_IDX_WDT_CTRL   8'hC1
`define WDRS_IDX_PWR_CTRL   8'h87
`define WDRS_IDX_FLASH_CTRL 8'hC7
`define WDRS_IDX_STATUS     8'hF0
`define WDRS_ADDR_WDT_CTRL   {`WDRS_IDX_WDT_CTRL, 2'b00}
`define WDRS_ADDR_PWR_CTRL   {`WDRS_IDX_PWR_CTRL, 2'b00}
`define WDRS_ADDR_FLASH_CTRL {`WDRS_IDX_FLASH_CTRL, 2'b00}
`define WDRS_ADDR_STATUS     {`WDRS_IDX_STATUS, 2'b00}
// ==========================================================================
// Field positions.
`define WDRS_WATCHDOG_RESET_FLAG_BIT    7
`define WDRS_WDT_EN_BIT      5
`define WDRS_WDT_CLR_BIT     4
`define WDRS_WDT_IDLE_BIT    3
`define WDRS_PWR_POF_BIT     4
`define WDRS_FL_BOOT_BIT     6
`define WDRS_FL_SOFTWARE_RESET_TRIGGER_BIT    5
`define WDRS_FL_CMD_WARM     8'h20
`define WDRS_FL_CMD_COLD     8'h60
// ==========================================================================
// Reset values.
`define WDRS_WDT_CTRL_RST    8'h00
`define WDRS_PWR_CTRL_RST    8'h10
`define WDRS_FLASH_CTRL_RST  8'h00
// ==========================================================================
// Timing.
`define WDRS_POR_CYCLES      32768
`define WDRS_EXTRA_DELAY_MS  200
`define WDRS_CLK_HZ          100000000
`define WDRS_EXTRA_CYCLES    ((`WDRS_EXTRA_DELAY_MS * (`WDRS_CLK_HZ / 1000)))
`define WDRS_WDT_PRE12       12
`define WDRS_CNT_BITS        15
`define WDRS_BOOT_WAIT_CYCLES 1000000
`endif

// ===== wdrs_top.v
// Watchdog timer and reset-source logic with an APB register slave.
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ps
`include "wdrs_map.vh"

// Behaviour
// - After power returns, hold internal reset 32768 clocks, then release it.
// - Power-on reset sets the power-on flag; only software clears it.
// - Optional strap adds about 200 ms extra power-up reset delay.
// - Watchdog is an 8-bit prescaler feeding a 15-bit counter; overflow times out.
// - Writing 1 to the enable bit, bit 5, starts the watchdog.
// - Clearing the enable bit stops the watchdog counting.
// - Watchdog overflow generates an internal system reset.
// - Overflow sets the watchdog flag, bit 7; only software writing 0 or a power-on reset clears it.
// - Writing restart makes the watchdog recount; hardware clears the bit.
// - Idle-run bit 1 keeps counting in idle; 0 stops it in idle.
// - Prescale field n divides by two to the power n plus one.
// - Timeout equals 12 times prescale times 32768 clock periods.
// - Watchdog, reset pin or writing 20H restarts at the application area.
// - Power-on or writing 60H starts the boot monitor area.
// - Watchdog reset leaves internal data RAM untouched.
// - Strap option write-protects watchdog control except the restart bit.
// - Software reset trigger causes full system reset and self-clears.
// - Boot-select bit 6 picks the area after software reset: 1 boot, 0 application.
module wdrs_top #(
   parameter POR_CYCLES   = `WDRS_POR_CYCLES,
   parameter EXTRA_CYCLES = `WDRS_EXTRA_CYCLES,
   parameter SYSRST_LEN   = 4,
   parameter CNT_BITS     = `WDRS_CNT_BITS,
   parameter BOOT_WAIT_CYCLES = `WDRS_BOOT_WAIT_CYCLES
) (
   input  wire        sys_clk_i,
   input  wire        rst_i,
   input  wire        clk_en_i,
   input  wire        por_i,
   input  wire        pin_reset_i,
   input  wire        extra_delay_opt_i,
   input  wire        wdt_protect_opt_i,
   input  wire        idle_i,
   input  wire        boot_cmd_valid_i,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   output reg         sys_reset_o,
   output reg         ram_clear_o,
   output reg         boot_area_o,
   output reg         wdt_timeout_o
);

   // ==========================================================================
   // Reset sequencing.
   // The por_i level is the analog detector; rst_i resets this block only
   // on the very first power-up, so POR stretching restarts from por_i.
   localparam [1:0] ST_POR   = 2'd0;
   localparam [1:0] ST_EXTRA = 2'd1;
   localparam [1:0] ST_SYS   = 2'd2;
   localparam [1:0] ST_RUN   = 2'd3;

   // Delay terminal counts are held at 32 bits so every compare matches dly_r; DIV12_END is cut to 4 bits for div12_r.
   localparam [31:0] POR_END    = POR_CYCLES - 1;
   localparam [31:0] EXTRA_END  = EXTRA_CYCLES - 1;
   localparam [31:0] SYS_END    = SYSRST_LEN - 1;
   localparam [31:0] BOOT_END   = BOOT_WAIT_CYCLES - 1;
   localparam [31:0] DIV12_FULL = `WDRS_WDT_PRE12 - 1;
   localparam [3:0]  DIV12_END  = DIV12_FULL[3:0];
   localparam [11:0] ADDR_WDT   = {2'b00, `WDRS_ADDR_WDT_CTRL};
   localparam [11:0] ADDR_PWR   = {2'b00, `WDRS_ADDR_PWR_CTRL};
   localparam [11:0] ADDR_FL    = {2'b00, `WDRS_ADDR_FLASH_CTRL};
   localparam [11:0] ADDR_STAT  = {2'b00, `WDRS_ADDR_STATUS};

   reg  [1:0]  state_r;
   reg  [31:0] dly_r;
   reg         cold_r;
   reg  [7:0]  wdt_ctrl_r;
   reg         pof_r;
   reg  [7:0]  flash_ctrl_r;
   reg  [7:0]  pre_r;
   reg  [CNT_BITS-1:0] cnt_r;
   reg  [3:0]  div12_r;
   reg         wdt_ovf_r;
   reg         sw_rst_r;
   reg         boot_wait_r;
   reg         boot_sel_r;

   wire acc   = psel & penable;
   wire wr    = acc & pwrite;
   wire hit_w = (paddr == ADDR_WDT);
   wire hit_p = (paddr == ADDR_PWR);
   wire hit_f = (paddr == ADDR_FL);
   wire hit_s = (paddr == ADDR_STAT);
   wire mapped = hit_w | hit_p | hit_f | hit_s;
   wire [7:0] wb = pwdata[7:0];

   wire run    = (state_r == ST_RUN);
   wire cmd_wf = wr & hit_f & (wb == `WDRS_FL_CMD_WARM);
   wire cmd_cf = wr & hit_f & (wb == `WDRS_FL_CMD_COLD);
   wire software_reset_trigger  = wr & hit_f & wb[`WDRS_FL_SOFTWARE_RESET_TRIGGER_BIT];

   // ==========================================================================
   // Prescaler division 2^(ps+1): terminal mask of the 8-bit stage.
   // A table rather than a shift keeps the divide-by-256 case from wrapping.
   reg  [7:0] pre_mask;
   always @* begin
      case (wdt_ctrl_r[2:0])
         3'h0:    pre_mask = 8'h01;
         3'h1:    pre_mask = 8'h03;
         3'h2:    pre_mask = 8'h07;
         3'h3:    pre_mask = 8'h0F;
         3'h4:    pre_mask = 8'h1F;
         3'h5:    pre_mask = 8'h3F;
         3'h6:    pre_mask = 8'h7F;
         3'h7:    pre_mask = 8'hFF;
         default: pre_mask = 8'hFF;
      endcase
   end

   wire counting = run & wdt_ctrl_r[`WDRS_WDT_EN_BIT]
                   & (~idle_i | wdt_ctrl_r[`WDRS_WDT_IDLE_BIT]);
   wire tick12 = counting & (div12_r == DIV12_END);
   wire pre_end = tick12 & ((pre_r & pre_mask) == pre_mask);
   wire overflow = pre_end & (cnt_r == {CNT_BITS{1'b1}});
   wire restart = wr & hit_w & wb[`WDRS_WDT_CLR_BIT];

   // ==========================================================================
   // Sequencer and reset outputs.
   always @(posedge sys_clk_i) begin
      if (rst_i | por_i) begin
         state_r     <= ST_POR;
         dly_r       <= 32'h00000000;
         cold_r      <= 1'b1;
         sys_reset_o <= 1'b1;
         ram_clear_o <= 1'b1;
         boot_area_o <= 1'b1;
         boot_sel_r  <= 1'b1;
         boot_wait_r <= 1'b0;
         wdt_timeout_o <= 1'b0;
      end else if (clk_en_i) begin
         wdt_timeout_o <= overflow;
         case (state_r)
            ST_POR: begin
               if (dly_r == POR_END) begin
                  dly_r   <= 32'h00000000;
                  state_r <= extra_delay_opt_i ? ST_EXTRA : ST_SYS;
               end else begin
                  dly_r <= dly_r + 32'h00000001;
               end
            end
            ST_EXTRA: begin
               if (dly_r == EXTRA_END) begin
                  dly_r   <= 32'h00000000;
                  state_r <= ST_SYS;
               end else begin
                  dly_r <= dly_r + 32'h00000001;
               end
            end
            ST_SYS: begin
               if (dly_r == SYS_END) begin
                  dly_r       <= 32'h00000000;
                  state_r     <= ST_RUN;
                  sys_reset_o <= 1'b0;
                  ram_clear_o <= 1'b0;
                  boot_area_o <= boot_sel_r;
                  boot_wait_r <= boot_sel_r;
                  cold_r      <= 1'b0;
               end else begin
                  dly_r <= dly_r + 32'h00000001;
               end
            end
            ST_RUN: begin
               if (overflow | pin_reset_i | cmd_wf) begin
                  state_r     <= ST_SYS;
                  sys_reset_o <= 1'b1;
                  boot_sel_r  <= 1'b0;
                  dly_r       <= 32'h00000000;
               end else if (cmd_cf | software_reset_trigger) begin
                  state_r     <= ST_SYS;
                  sys_reset_o <= 1'b1;
                  boot_sel_r  <= wb[`WDRS_FL_BOOT_BIT];
                  dly_r       <= 32'h00000000;
               end else if (boot_wait_r & boot_cmd_valid_i) begin
                  boot_wait_r <= 1'b0;
                  dly_r       <= 32'h00000000;
               end else if (boot_wait_r & (dly_r == BOOT_END)) begin
                  // No valid command reached the monitor, so fall back to the application.
                  state_r     <= ST_SYS;
                  sys_reset_o <= 1'b1;
                  boot_sel_r  <= 1'b0;
                  dly_r       <= 32'h00000000;
               end else if (boot_wait_r) begin
                  dly_r <= dly_r + 32'h00000001;
               end
               // RAM keeps its contents on every warm restart.
               ram_clear_o <= 1'b0;
            end
            default: state_r <= ST_POR;
         endcase
      end
   end

   // ==========================================================================
   // Watchdog counter.
   always @(posedge sys_clk_i) begin
      if (rst_i | por_i) begin
         pre_r   <= 8'h00;
         cnt_r   <= {CNT_BITS{1'b0}};
         div12_r <= 4'h0;
      end else if (clk_en_i) begin
         if (restart | ~run) begin
            pre_r   <= 8'h00;
            cnt_r   <= {CNT_BITS{1'b0}};
            div12_r <= 4'h0;
         end else if (counting) begin
            div12_r <= tick12 ? 4'h0 : div12_r + 4'h1;
            if (tick12) begin
               pre_r <= pre_end ? 8'h00 : pre_r + 8'h01;
               if (pre_end) begin
                  cnt_r <= cnt_r + {{(CNT_BITS-1){1'b0}}, 1'b1};
               end
            end
         end
      end
   end

   // ==========================================================================
   // Registers. The watchdog flag and power-on flag survive warm resets.
   always @(posedge sys_clk_i) begin
      if (rst_i | por_i) begin
         wdt_ctrl_r   <= `WDRS_WDT_CTRL_RST;
         pof_r        <= 1'b1;
         flash_ctrl_r <= `WDRS_FLASH_CTRL_RST;
         sw_rst_r     <= 1'b0;
      end else if (clk_en_i) begin
         sw_rst_r <= software_reset_trigger;
         if (state_r == ST_SYS) begin
            wdt_ctrl_r[6:0] <= 7'h00;
            flash_ctrl_r[5:0] <= 6'h00;
         end else begin
            if (wr & hit_w & ~wdt_protect_opt_i) begin
               wdt_ctrl_r[6:0] <= {1'b0, wb[5], 1'b0, wb[3:0]};
               if (~wb[`WDRS_WATCHDOG_RESET_FLAG_BIT]) begin
                  wdt_ctrl_r[7] <= 1'b0;
               end
            end
            if (wr & hit_p & ~wb[`WDRS_PWR_POF_BIT]) begin
               pof_r <= 1'b0;
            end
            if (wr & hit_f) begin
               flash_ctrl_r <= {wb[7:6], 1'b0, wb[4:0]};
            end
         end
         if (overflow) begin
            wdt_ctrl_r[7] <= 1'b1;
         end
      end
   end

   // ==========================================================================
   // Read multiplexer; every register is one byte, upper bits read zero.
   reg  [7:0] rd_byte;
   always @* begin
      rd_byte = 8'h00;
      if (hit_w) begin
         rd_byte = wdt_ctrl_r;
      end
      if (hit_p) begin
         rd_byte = {3'b000, pof_r, 4'h0};
      end
      if (hit_f) begin
         rd_byte = flash_ctrl_r;
      end
      if (hit_s) begin
         rd_byte = {5'h00, boot_wait_r, cold_r, boot_sel_r};
      end
   end

   // ==========================================================================
   // APB slave, zero wait states.
   always @(posedge sys_clk_i) begin
      if (rst_i) begin
         prdata  <= 32'h00000000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else if (clk_en_i) begin
         pready  <= psel & ~penable;
         pslverr <= psel & ~penable & ~mapped;
         if (psel & ~penable & ~pwrite) begin
            prdata <= {24'h000000, rd_byte};
         end
      end
   end

endmodule

// ===== wdrs_top_assertions.sv
// Concurrent checks on the ports of the watchdog and reset-source block.
`timescale 1ns/1ps
`include "wdrs_map.vh"
// ==========================================================================
// Checker
module wdrs_checker #(
   parameter POR_CYCLES   = 16,
   parameter EXTRA_CYCLES = 8,
   parameter SYSRST_LEN   = 4
) (
   input wire        sys_clk_i,
   input wire        rst_i,
   input wire        clk_en_i,
   input wire        pin_reset_i,
   input wire        psel,
   input wire        penable,
   input wire        pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire        pready,
   input wire        sys_reset_o,
   input wire        ram_clear_o,
   input wire        boot_area_o,
   input wire        wdt_timeout_o
);
   localparam [11:0] FL_A = {2'b00, `WDRS_ADDR_FLASH_CTRL};
   reg [31:0] por_cnt_r;
   reg        por_r;
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);
   // The counter follows only the power-up phase, so warm resets never disturb it.
   always @(posedge sys_clk_i) begin
      if (rst_i) begin
         por_cnt_r <= 32'h0;
         por_r     <= 1'b1;
      end else if (por_r) begin
         por_cnt_r <= por_cnt_r + 32'h1;
         por_r     <= sys_reset_o;
      end
   end
   por_min_a: assert property (por_r && !sys_reset_o |-> por_cnt_r >= POR_CYCLES)
      else $error("reset released too early");
   por_max_a: assert property (por_r |-> por_cnt_r <= POR_CYCLES + SYSRST_LEN + EXTRA_CYCLES + 4)
      else $error("reset held too long");
   cold_area_a: assert property ($fell(rst_i) |-> (ram_clear_o && boot_area_o) [*4])
      else $error("cold start not toward boot area");
   ram_cold_a: assert property (ram_clear_o |-> sys_reset_o)
      else $error("ram clear outside reset");
   wdt_reset_a: assert property (wdt_timeout_o |-> ##[0:2] (sys_reset_o && !ram_clear_o))
      else $error("overflow without warm reset");
   wdt_pulse_a: assert property (wdt_timeout_o |=> !wdt_timeout_o)
      else $error("overflow pulse too long");
   wdt_warm_a: assert property (wdt_timeout_o |-> ##[1:6] !boot_area_o)
      else $error("overflow not toward application");
   pin_warm_a: assert property (pin_reset_i && clk_en_i && !sys_reset_o |-> ##[1:3] sys_reset_o)
      else $error("pin reset ignored");
   sw_reset_a: assert property (psel && penable && pready && pwrite && paddr == FL_A && pwdata[5]
      && !sys_reset_o |-> ##[1:3] sys_reset_o)
      else $error("software reset ignored");
endmodule
bind wdrs_top wdrs_checker #(.POR_CYCLES(POR_CYCLES), .EXTRA_CYCLES(EXTRA_CYCLES), .SYSRST_LEN(SYSRST_LEN))
   wdrs_checker_i (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .clk_en_i(clk_en_i), .pin_reset_i(pin_reset_i),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
   .sys_reset_o(sys_reset_o), .ram_clear_o(ram_clear_o), .boot_area_o(boot_area_o),
   .wdt_timeout_o(wdt_timeout_o));

// ===== tb_wdrs_top.sv
// Self-checking bench for the watchdog and reset-source block.
`timescale 1ns/1ps
`include "wdrs_map.vh"
// ==========================================================================
// Bench
module tb_wdrs_top;
   localparam logic [11:0] A_WDT = {2'b00, `WDRS_ADDR_WDT_CTRL};
   localparam logic [11:0] A_PWR = {2'b00, `WDRS_ADDR_PWR_CTRL};
   localparam logic [11:0] A_FL  = {2'b00, `WDRS_ADDR_FLASH_CTRL};
   logic        sys_clk_i   = 1'b0;
   logic        rst_i       = 1'b1;
   logic        pin_reset_i = 1'b0;
   logic        clk_en_i    = 1'b1;
   logic        idle_i      = 1'b0;
   logic        wdt_timeout_o;
   logic        extra_i     = 1'b0;
   logic        prot_i      = 1'b0;
   logic        psel        = 1'b0;
   logic        penable     = 1'b0;
   logic        pwrite      = 1'b0;
   logic [11:0] paddr       = 12'h000;
   logic [31:0] pwdata      = 32'h0;
   logic [31:0] prdata, rd;
   logic        pready, pslverr, err, sys_reset_o, ram_clear_o, boot_area_o;
   int          n_mismatch  = 0;
   int          checked     = 0;
   int          cyc         = 0;
   int          n;
   // Shortened counts and a 4-bit counter stage let a full timeout fit in the run.
   wdrs_top #(.POR_CYCLES(16), .EXTRA_CYCLES(8), .SYSRST_LEN(4), .CNT_BITS(4), .BOOT_WAIT_CYCLES(200))
      wdrs_top_i (.sys_clk_i(sys_clk_i),
      .rst_i(rst_i), .clk_en_i(clk_en_i), .por_i(1'b0), .pin_reset_i(pin_reset_i), .extra_delay_opt_i(extra_i),
      .wdt_protect_opt_i(prot_i), .idle_i(idle_i), .boot_cmd_valid_i(1'b0), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .sys_reset_o(sys_reset_o), .ram_clear_o(ram_clear_o), .boot_area_o(boot_area_o),
      .wdt_timeout_o(wdt_timeout_o));
   always #5 sys_clk_i = ~sys_clk_i;
   always @(posedge sys_clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 6000) begin
         n_mismatch = n_mismatch + 1;
         complete_run();
      end
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked = checked + 1;
      if (seen !== exp) begin
         n_mismatch = n_mismatch + 1;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   // The trailing edge keeps two requests from touching psel in one time step.
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge sys_clk_i);
      penable <= 1'b1;
      @(posedge sys_clk_i);
      while (pready !== 1'b1) @(posedge sys_clk_i);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge sys_clk_i);
   endtask
   task automatic run_wait();
      n = 0;
      while (sys_reset_o !== 1'b0 && n < 200) begin
         @(posedge sys_clk_i);
         n = n + 1;
      end
   endtask
   task automatic por(input logic x);
      extra_i <= x;
      rst_i   <= 1'b1;
      repeat (20) @(posedge sys_clk_i);
      rst_i <= 1'b0;
      run_wait();
   endtask
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   initial begin
      por(1'b0);
      chk(32'(n >= 16 && n <= 24), 32'h1);
      chk({31'h0, boot_area_o}, 32'h1);
      apb(1'b0, A_PWR, 32'h0);
      chk(rd & 32'h10, 32'h10);
      apb(1'b1, A_PWR, 32'h0);
      apb(1'b0, A_PWR, 32'h0);
      chk(rd & 32'h10, 32'h0);
      $display("test power-on done");
      for (int i = 0; i < 8; i++) begin
         apb(1'b1, A_WDT, 32'h28 | 32'(i));
         apb(1'b0, A_WDT, 32'h0);
         chk(rd, 32'h28 | 32'(i));
      end
      apb(1'b1, A_WDT, 32'h37);
      apb(1'b0, A_WDT, 32'h0);
      chk(rd, 32'h27);
      apb(1'b1, A_WDT, 32'h02);
      apb(1'b0, A_WDT, 32'h0);
      chk(rd, 32'h02);
      prot_i <= 1'b1;
      apb(1'b1, A_WDT, 32'h25);
      apb(1'b0, A_WDT, 32'h0);
      chk(rd, 32'h02);
      prot_i <= 1'b0;
      apb(1'b0, 12'h004, 32'h0);
      chk({31'h0, err}, 32'h1);
      chk(rd, 32'h0);
      $display("test registers done");
      apb(1'b1, A_WDT, 32'h20);
      for (int k = 0; k < 4; k++) begin
         if (k == 1) begin
            pin_reset_i <= 1'b1;
            @(posedge sys_clk_i);
            pin_reset_i <= 1'b0;
         end else begin
            apb(1'b1, A_FL, (k == 3) ? `WDRS_FL_CMD_WARM : `WDRS_FL_CMD_COLD);
         end
         repeat (2) @(posedge sys_clk_i);
         chk({31'h0, sys_reset_o}, 32'h1);
         run_wait();
         chk({31'h0, boot_area_o}, 32'(k % 2 == 0));
      end
      apb(1'b0, A_WDT, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, A_FL, 32'h0);
      chk(rd & 32'h20, 32'h0);
      apb(1'b0, A_PWR, 32'h0);
      chk(rd & 32'h10, 32'h0);
      $display("test warm resets done");
      apb(1'b1, A_WDT, 32'h20);
      idle_i <= 1'b1;
      repeat (50) @(posedge sys_clk_i);
      idle_i   <= 1'b0;
      clk_en_i <= 1'b0;
      repeat (30) @(posedge sys_clk_i);
      clk_en_i <= 1'b1;
      n = 0;
      while (wdt_timeout_o !== 1'b1 && n < 1000) begin
         @(posedge sys_clk_i);
         n = n + 1;
      end
      chk(n, 12 * 2 * (1 << 4));
      @(posedge sys_clk_i);
      chk({31'h0, wdt_timeout_o}, 32'h0);
      chk({31'h0, sys_reset_o}, 32'h1);
      run_wait();
      chk({31'h0, boot_area_o}, 32'h0);
      apb(1'b0, A_WDT, 32'h0);
      chk(rd, 32'h80);
      apb(1'b1, A_WDT, 32'h0);
      apb(1'b0, A_WDT, 32'h0);
      chk(rd, 32'h0);
      $display("test watchdog timeout done");
      por(1'b1);
      chk(32'(n >= 24 && n <= 32), 32'h1);
      apb(1'b0, A_PWR, 32'h0);
      chk(rd & 32'h10, 32'h10);
      $display("test extra delay done");
      n = 0;
      while (sys_reset_o !== 1'b1 && n < 400) begin
         @(posedge sys_clk_i);
         n = n + 1;
      end
      chk({31'h0, sys_reset_o}, 32'h1);
      run_wait();
      chk({31'h0, boot_area_o}, 32'h0);
      $display("test boot wait done");
      complete_run();
   end
endmodule
